// ==== common/dup_pkg.sv ====
// constants, register layout and types for the dual uart pin-control block
// Functional notes
// - select high: read strobe is active low
// - select low: read strobe pin ignored, tied high
// - select high/floating: write strobe active low
// - select low: direction line high read, low write
// - select high, control bit 3 set: interrupt driven, user output low
// - select high, bit 3 clear: interrupt tristated, user output high
// - select high/floating: master reset active high
// - select low: master reset active low
// - ring indicator low means ring present
// - ring rising edge interrupts when modem-status enabled
// - control bit 1 drives request-to-send low
// - request-to-send high after any reset
// - loopback feeds transmit data into receiver
// - receive ready low when a character waits
// - dma mode 1: high below trigger or empty
// - receive ready also serves dma mode 0
// - select low: one shared open-drain interrupt
`default_nettype none
package dup_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int LVL_W = 8;
	localparam int NCH = 2;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL_A = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_CTRL_B = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_PIN_STAT = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_INT_STAT = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h010;
	// per-channel modem control word, bit 1 and bit 3 as in the modem control register
	typedef struct packed {
		logic [LVL_W-1:0] trig;
		logic rsv7;
		logic dma_mode;
		logic msi_en;
		logic loopback;
		logic out_ctl;
		logic rsv2;
		logic rts;
		logic rsv0;
	} dup_ctrl_t;
	localparam logic [15:0] CTRL_WMASK = 16'hff7a;
	localparam dup_ctrl_t CTRL_RST = dup_ctrl_t'(16'h0100);
	// interrupt status / mask bits
	localparam int INT_W = 3;
	localparam int INT_RING_A = 0;
	localparam int INT_RING_B = 1;
	localparam int INT_DEV_RST = 2;
	// pin status bits
	localparam int PS_STYLE = 0;
	localparam int PS_DEV_RST = 1;
	localparam int PS_RING_LSB = 2;
	localparam int PS_RXRDY_LSB = 4;
	localparam int PS_RTS_LSB = 6;
	localparam int PS_W = 8;
endpackage
`default_nettype wire

// ==== src/dup_pin_ctrl.sv ====
// dual uart pin control: host strobe decode, reset polarity, modem pins, apb registers
//
// The APB slave port and the placing of the registers were left to the implementer.
`default_nettype none
module dup_pin_ctrl import dup_pkg::*; #(
	parameter int TRIG_MAX = 128
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic bus_style_sel,
	input wire logic host_cs_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic master_reset_pin,
	output logic host_read,
	output logic host_write,
	output logic device_reset,
	input wire logic ring_indicator_ch_a,
	input wire logic ring_indicator_ch_b,
	input wire logic core_irq_ch_a,
	input wire logic core_irq_ch_b,
	input wire logic tx_data_ch_a,
	input wire logic tx_data_ch_b,
	input wire logic serial_in_ch_a,
	input wire logic serial_in_ch_b,
	input wire logic [LVL_W-1:0] rx_level_ch_a,
	input wire logic [LVL_W-1:0] rx_level_ch_b,
	output logic rx_to_core_ch_a,
	output logic rx_to_core_ch_b,
	output logic serial_out_ch_a,
	output logic serial_out_ch_b,
	output logic request_to_send_ch_a,
	output logic request_to_send_ch_b,
	output logic user_output_ch_a,
	output logic user_output_ch_b,
	output logic receive_ready_ch_a,
	output logic receive_ready_ch_b,
	output logic interrupt_out_ch_a,
	output logic interrupt_out_ch_a_oe,
	output logic interrupt_out_ch_b,
	output logic interrupt_out_ch_b_oe
);

	// the trigger compare is only as wide as the level inputs
	if (TRIG_MAX < 1 || TRIG_MAX > (1 << LVL_W) - 1) begin : g_bad_trig
		$error("TRIG_MAX out of range for the level width");
	end

	////////////////////////////////////////////////////////////////////////////////
	// register map, one 32-bit word each
	//   ctrl a / ctrl b: [1] rts, [3] out_ctl, [4] loopback, [5] msi_en,
	//     [6] dma_mode, [15:8] receive trigger; reset leaves only trigger 1
	//   pin status (read only): [0] style, [1] device reset, [3:2] ring present,
	//     [5:4] receive ready pins, [7:6] request-to-send pins
	//   interrupt status: write one to clear; an event in the same cycle wins
	//   interrupt mask: same layout as status, resets to all masked
	// unmapped words answer with pslverr, read as zero and ignore writes
	// in separate style bit 3 steers the interrupt pin enable and the user output together, so
	// software is expected to use only one of the two per channel

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// empty storage always reads as not ready; a trigger of zero acts as one
	// mode 0 answers per character, mode 1 waits for the trigger level;
	// the pin is active low, so a one means nothing to fetch
	function automatic logic rx_ready_n(input logic [LVL_W-1:0] lvl,
			input logic [LVL_W-1:0] trig, input logic mode1);
		logic [LVL_W-1:0] eff;
		eff = (trig == '0) ? LVL_W'(1) : trig;
		if (lvl == '0)
			return 1'b1;
		if (mode1 && lvl < eff)
			return 1'b1;
		return 1'b0;
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return a == OFS_CTRL_A || a == OFS_CTRL_B || a == OFS_PIN_STAT ||
			a == OFS_INT_STAT || a == OFS_INT_MASK;
	endfunction

	// a write lands only on the edge that completes the access
	function automatic logic wr_hit(input logic en, input logic [ADDR_W-1:0] a,
			input logic [ADDR_W-1:0] ofs);
		return en && a == ofs;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state

	dup_ctrl_t ctrl [NCH];
	logic [INT_W-1:0] int_stat;
	logic [INT_W-1:0] int_mask;
	logic [NCH-1:0] ri_prev;
	logic [NCH-1:0] rts_q;
	logic [NCH-1:0] rxrdy_q;

	// per-channel views of the pin inputs
	logic [NCH-1:0] ri_in;
	logic [NCH-1:0] core_irq;
	logic [NCH-1:0] tx_in;
	logic [NCH-1:0] sin;
	logic [NCH-1:0] chan_int;
	logic [NCH-1:0] ring_rise;
	logic [LVL_W-1:0] lvl [NCH];

	// decode and event terms
	logic next_dev_rst;
	logic wr_en;
	logic [INT_W-1:0] int_set;
	logic [PS_W-1:0] pin_stat;

	assign ri_in = {ring_indicator_ch_b, ring_indicator_ch_a};
	assign core_irq = {core_irq_ch_b, core_irq_ch_a};
	assign tx_in = {tx_data_ch_b, tx_data_ch_a};
	assign sin = {serial_in_ch_b, serial_in_ch_a};
	assign lvl[0] = rx_level_ch_a;
	assign lvl[1] = rx_level_ch_b;

	////////////////////////////////////////////////////////////////////////////////
	// host strobe decode and reset polarity

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_read <= 1'b0;
		end else if (bus_style_sel) begin
			host_read <= !host_cs_n && !read_strobe_n;
		end else begin
			// the separate read strobe is ignored; a high direction line reads
			host_read <= !host_cs_n && write_strobe_n;
		end
	end

	// the write decode is the same low level in both styles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_write <= 1'b0;
		end else if (bus_style_sel) begin
			host_write <= !host_cs_n && !write_strobe_n;
		end else begin
			host_write <= !host_cs_n && !write_strobe_n;
		end
	end

	assign next_dev_rst = bus_style_sel ? master_reset_pin : !master_reset_pin;

	// style 1 reads the pin as active high, style 0 as active low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			device_reset <= 1'b0;
		end else begin
			device_reset <= next_dev_rst;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, answer on the second access cycle

	assign wr_en = psel && penable && pready && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	// an unmapped word is refused in the same cycle that answers it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && penable && !pready && !is_mapped(paddr);
		end
	end

	// read data is captured once and then holds while pready stands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && penable && !pready && !pwrite) begin
			case (paddr)
				OFS_CTRL_A: prdata <= DATA_W'(16'(ctrl[0]) & CTRL_WMASK);
				OFS_CTRL_B: prdata <= DATA_W'(16'(ctrl[1]) & CTRL_WMASK);
				OFS_PIN_STAT: prdata <= DATA_W'(pin_stat);
				OFS_INT_STAT: prdata <= DATA_W'(int_stat);
				OFS_INT_MASK: prdata <= DATA_W'(int_mask);
				default: prdata <= '0;
			endcase
		end
	end

	// pin status fields sit at the positions the package names
	assign pin_stat[PS_STYLE] = bus_style_sel;
	assign pin_stat[PS_DEV_RST] = device_reset;
	assign pin_stat[PS_RING_LSB +: NCH] = ~ri_in;
	assign pin_stat[PS_RXRDY_LSB +: NCH] = rxrdy_q;
	assign pin_stat[PS_RTS_LSB +: NCH] = rts_q;

	// the device reset returns control words to default, like a power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl[0] <= CTRL_RST;
			ctrl[1] <= CTRL_RST;
		end else if (device_reset) begin
			ctrl[0] <= CTRL_RST;
			ctrl[1] <= CTRL_RST;
		end else if (wr_hit(wr_en, paddr, OFS_CTRL_A)) begin
			ctrl[0] <= dup_ctrl_t'(pwdata[15:0] & CTRL_WMASK);
		end else if (wr_hit(wr_en, paddr, OFS_CTRL_B)) begin
			ctrl[1] <= dup_ctrl_t'(pwdata[15:0] & CTRL_WMASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask <= '0;
		end else if (wr_hit(wr_en, paddr, OFS_INT_MASK)) begin
			int_mask <= pwdata[INT_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// ring detection and interrupt status

	assign ring_rise = ri_in & ~ri_prev;
	// the device reset event marks only the first cycle of a reset
	assign int_set[INT_DEV_RST] = next_dev_rst && !device_reset;
	assign int_set[INT_RING_B:INT_RING_A] = ring_rise;

	// idle ring lines are high, so the history resets high to avoid a false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ri_prev <= {NCH{1'b1}};
		end else begin
			ri_prev <= ri_in;
		end
	end

	// a new event in the clearing cycle survives the write of one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat <= '0;
		end else if (wr_hit(wr_en, paddr, OFS_INT_STAT)) begin
			int_stat <= (int_stat & ~pwdata[INT_W-1:0]) | int_set;
		end else begin
			int_stat <= int_stat | int_set;
		end
	end

	// the output lags the status by one cycle so that it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat & int_mask);
		end
	end

	// ring only reaches the channel pin when modem-status interrupts are on
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			chan_int[i] = core_irq[i] || (int_stat[i] && ctrl[i].msi_en);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// modem and serial pins

	// the pin follows the bit one cycle later; a device reset raises it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rts_q <= {NCH{1'b1}};
		end else begin
			for (int i = 0; i < NCH; i++) begin
				rts_q[i] <= !ctrl[i].rts;
			end
		end
	end

	assign request_to_send_ch_a = rts_q[0];
	assign request_to_send_ch_b = rts_q[1];

	// in separate style one bit steers both the pin enable and this output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_output_ch_a <= 1'b1;
		end else begin
			user_output_ch_a <= !ctrl[0].out_ctl;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_output_ch_b <= 1'b1;
		end else begin
			user_output_ch_b <= !ctrl[1].out_ctl;
		end
	end

	// separate style: each channel drives its own pin while bit 3 enables it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_out_ch_a <= 1'b0;
			interrupt_out_ch_a_oe <= 1'b0;
		end else if (bus_style_sel) begin
			interrupt_out_ch_a <= chan_int[0];
			interrupt_out_ch_a_oe <= ctrl[0].out_ctl;
		end else begin
			// open drain: pull low only while any channel requests
			interrupt_out_ch_a <= 1'b0;
			interrupt_out_ch_a_oe <= |chan_int;
		end
	end

	// combined style leaves the channel b pin unused and released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_out_ch_b <= 1'b0;
			interrupt_out_ch_b_oe <= 1'b0;
		end else if (bus_style_sel) begin
			interrupt_out_ch_b <= chan_int[1];
			interrupt_out_ch_b_oe <= ctrl[1].out_ctl;
		end else begin
			interrupt_out_ch_b <= 1'b0;
			interrupt_out_ch_b_oe <= 1'b0;
		end
	end

	// loopback disconnects the external line from the receiver
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_to_core_ch_a <= 1'b1;
			rx_to_core_ch_b <= 1'b1;
		end else begin
			rx_to_core_ch_a <= ctrl[0].loopback ? tx_in[0] : sin[0];
			rx_to_core_ch_b <= ctrl[1].loopback ? tx_in[1] : sin[1];
		end
	end

	// the transmit pin idles high while its data is looped back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_out_ch_a <= 1'b1;
			serial_out_ch_b <= 1'b1;
		end else begin
			serial_out_ch_a <= ctrl[0].loopback ? 1'b1 : tx_in[0];
			serial_out_ch_b <= ctrl[1].loopback ? 1'b1 : tx_in[1];
		end
	end

	// the level is compared each cycle, so the pin lags storage by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxrdy_q <= {NCH{1'b1}};
		end else begin
			for (int i = 0; i < NCH; i++) begin
				rxrdy_q[i] <= rx_ready_n(lvl[i], ctrl[i].trig, ctrl[i].dma_mode);
			end
		end
	end

	assign receive_ready_ch_a = rxrdy_q[0];
	assign receive_ready_ch_b = rxrdy_q[1];

endmodule // dup_pin_ctrl
`default_nettype wire

// ==== bench/dup_pin_ctrl_assertions.sv ====
// concurrent checks on the pin-control block ports
`default_nettype none
module dup_pin_ctrl_assertions import dup_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic irq,
	input wire logic bus_style_sel,
	input wire logic host_cs_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic master_reset_pin,
	input wire logic host_read,
	input wire logic host_write,
	input wire logic device_reset,
	input wire logic core_irq_ch_a,
	input wire logic serial_in_ch_a,
	input wire logic [LVL_W-1:0] rx_level_ch_a,
	input wire logic rx_to_core_ch_a,
	input wire logic serial_out_ch_a,
	input wire logic user_output_ch_a,
	input wire logic user_output_ch_b,
	input wire logic receive_ready_ch_a,
	input wire logic interrupt_out_ch_a,
	input wire logic interrupt_out_ch_a_oe,
	input wire logic interrupt_out_ch_b_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////////
	read_strobe_a: assert property (
		bus_style_sel && !host_cs_n && !read_strobe_n |=> host_read)
		else $error("separate read strobe not decoded");
	write_strobe_a: assert property (
		bus_style_sel && !host_cs_n && !write_strobe_n |=> host_write)
		else $error("separate write strobe not decoded");
	dir_line_a: assert property (
		!bus_style_sel && !host_cs_n |=> host_read == $past(write_strobe_n)
		&& host_write == !$past(write_strobe_n)) else $error("direction line decode wrong");
	reset_pol_a: assert property (
		1'b1 |=> device_reset == ($past(bus_style_sel) ~^ $past(master_reset_pin)))
		else $error("master reset polarity wrong");
	int_vs_user_a: assert property (
		$past(bus_style_sel) && bus_style_sel |-> interrupt_out_ch_a_oe != user_output_ch_a)
		else $error("interrupt enable and user output disagree");
	shared_int_a: assert property (
		!bus_style_sel && core_irq_ch_a |=> interrupt_out_ch_a_oe && !interrupt_out_ch_a)
		else $error("shared interrupt not pulled low");
	shared_b_off_a: assert property (!$past(bus_style_sel) |-> !interrupt_out_ch_b_oe)
		else $error("channel b interrupt driven in combined style");
	rx_empty_a: assert property (rx_level_ch_a == 8'h00 |=> receive_ready_ch_a)
		else $error("receive ready low while empty");
	rx_path_a: assert property (!serial_out_ch_a |-> rx_to_core_ch_a == $past(serial_in_ch_a))
		else $error("receiver not fed from serial input");
	apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready ##1 !pready)
		else $error("apb answer timing wrong");
	cover property ($rose(irq));
	cover property (host_write);
	cover property (device_reset);
	cover property (!receive_ready_ch_a);
endmodule // dup_pin_ctrl_assertions
`default_nettype wire

// ==== bench/dup_far_model.sv ====
// far side model: host strobe tie-off and modem ring lines
`default_nettype none
module dup_far_model (
	input wire logic bus_style_sel,
	input wire logic rd_n_req,
	input wire logic [1:0] ring_on,
	output logic read_strobe_n,
	output logic ring_indicator_ch_a,
	output logic ring_indicator_ch_b
);
	// in combined style the read strobe pin is unused and held at the rail
	assign read_strobe_n = bus_style_sel ? rd_n_req : 1'b1;
	assign ring_indicator_ch_a = !ring_on[0];
	assign ring_indicator_ch_b = !ring_on[1];
endmodule // dup_far_model
`default_nettype wire

// ==== bench/test_dup_pin_ctrl.sv ====
// testbench for the dual uart pin-control block
`default_nettype none
module test_dup_pin_ctrl import dup_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sty, cs_n, rdq, wr_n, mrst;
	logic host_read, host_write, device_reset, rd_n, ri_a, ri_b, se;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [1:0] ring_on, cirq, tx, sin, rxc, sout, rts, uo, rr, io, ioe;
	logic [LVL_W-1:0] lvl_a, lvl_b;
	int num_errors, num_checks, cyc;
	dup_pin_ctrl u_dup_pin_ctrl (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .irq, .bus_style_sel(sty), .host_cs_n(cs_n),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .master_reset_pin(mrst), .host_read,
		.host_write, .device_reset, .ring_indicator_ch_a(ri_a), .ring_indicator_ch_b(ri_b),
		.core_irq_ch_a(cirq[0]), .core_irq_ch_b(cirq[1]), .tx_data_ch_a(tx[0]),
		.tx_data_ch_b(tx[1]), .serial_in_ch_a(sin[0]), .serial_in_ch_b(sin[1]),
		.rx_level_ch_a(lvl_a), .rx_level_ch_b(lvl_b), .rx_to_core_ch_a(rxc[0]),
		.rx_to_core_ch_b(rxc[1]), .serial_out_ch_a(sout[0]), .serial_out_ch_b(sout[1]),
		.request_to_send_ch_a(rts[0]), .request_to_send_ch_b(rts[1]),
		.user_output_ch_a(uo[0]), .user_output_ch_b(uo[1]), .receive_ready_ch_a(rr[0]),
		.receive_ready_ch_b(rr[1]), .interrupt_out_ch_a(io[0]), .interrupt_out_ch_a_oe(ioe[0]),
		.interrupt_out_ch_b(io[1]), .interrupt_out_ch_b_oe(ioe[1]));
	dup_far_model u_dup_far_model (.bus_style_sel(sty), .rd_n_req(rdq), .ring_on,
		.read_strobe_n(rd_n), .ring_indicator_ch_a(ri_a), .ring_indicator_ch_b(ri_b));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 0;
		forever #2 pclk = !pclk;
	end
	task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// the master waits on pready only; the cycle ceiling catches a dead slave
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task wt;
		repeat (4) @(posedge pclk);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 3000) begin
			num_errors++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cs_n, rdq, wr_n, mrst} = '0;
		{sty, cs_n, rdq, wr_n, ring_on, cirq, tx, sin, lvl_a, lvl_b} = {4'hf, 8'h0f, 16'h0};
		repeat (8) @(posedge pclk);
		presetn <= 1;
		wt();
		check({rts, uo}, 4'hf);
		apb(0, OFS_CTRL_A, 0);
		check(rd, 32'h0100);
		apb(1, OFS_CTRL_A, 32'h0102);
		apb(1, OFS_CTRL_B, 32'h0108); // channel b sets bit 3: interrupt pin enabled, user output low
		wt();
		check({rts, uo, ioe}, 6'b10_01_10);
		for (int i = 0; i < 9; i++) begin
			{sty, rdq, wr_n} <= 3'(i) | 3'(4 * (i == 8));
			mrst <= !(i[2] || i == 8);
			cs_n <= (i == 8);
			wt();
			if (cs_n || !(sty && !rdq && !wr_n))
				check({host_read, host_write},
					cs_n ? 2'b00 : {sty ? !rdq : wr_n, !wr_n});
		end
		{mrst, sty} <= 2'b11;
		wt();
		check({device_reset, rts}, 3'b111);
		{mrst, sty} <= 2'b00;
		wt();
		check(device_reset, 1);
		{mrst, sty} <= 2'b01;
		wt();
		check(device_reset, 0);
		apb(1, OFS_INT_MASK, 3);
		apb(1, OFS_INT_STAT, 7);
		apb(1, OFS_CTRL_A, 32'h0128); // channel a uses only its interrupt output
		ring_on <= 2'b01;
		wt();
		ring_on <= 2'b00;
		wt();
		check({irq, io[0], ioe[0]}, 3'b111);
		apb(0, OFS_INT_STAT, 0);
		check(rd, 32'h1);
		apb(1, OFS_INT_STAT, 1);
		wt();
		check({irq, io[0]}, 2'b00);
		apb(1, OFS_CTRL_A, 32'h0110);
		{tx, sin} <= 4'b0011;
		wt();
		check({sout, rxc}, 4'b0110);
		apb(1, OFS_CTRL_A, 32'h0100);
		lvl_a <= 1;
		wt();
		check(rr[0], 0);
		apb(1, OFS_CTRL_A, 32'h0440);
		lvl_a <= 3;
		wt();
		check(rr[0], 1);
		lvl_a <= 4;
		wt();
		check(rr[0], 0);
		apb(0, 12'h020, 0);
		check({se, rd}, {1'b1, 32'h0});
		{mrst, sty, cirq} <= 4'b1011;
		wt();
		check({io, ioe, rr[1]}, 5'b00011);
		apb(0, OFS_PIN_STAT, 0);
		check(rd, 32'he0);
		final_report();
	end
endmodule // test_dup_pin_ctrl
bind dup_pin_ctrl dup_pin_ctrl_assertions u_dup_pin_ctrl_assertions (.pclk, .presetn, .psel,
	.penable, .pready, .irq, .bus_style_sel, .host_cs_n, .read_strobe_n, .write_strobe_n,
	.master_reset_pin, .host_read, .host_write, .device_reset, .core_irq_ch_a, .serial_in_ch_a,
	.rx_level_ch_a, .rx_to_core_ch_a, .serial_out_ch_a, .user_output_ch_a, .user_output_ch_b,
	.receive_ready_ch_a, .interrupt_out_ch_a, .interrupt_out_ch_a_oe, .interrupt_out_ch_b_oe);
`default_nettype wire
